/* src/regulator_control_registers_regs.vh */
`ifndef REGULATOR_CONTROL_REGISTERS_REGS_VH
`define REGULATOR_CONTROL_REGISTERS_REGS_VH

// Register indices; byte address is four times the index
`define IDX_BUCK1_CTL 8'h12
`define IDX_BUCK2_PRI 8'h20
`define IDX_BUCK2_SEC 8'h21
`define IDX_BUCK2_CTL 8'h22
`define IDX_BUCK3_PRI 8'h30
`define IDX_BUCK3_SEC 8'h31
`define IDX_BUCK3_CTL 8'h32
`define IDX_BUCK4_PRI 8'h40
`define IDX_BUCK4_SEC 8'h41
`define IDX_BUCK4_CTL 8'h42
`define IDX_LDO5_VOLT 8'h50
`define IDX_LDO5_CTL 8'h51
`define IDX_LDO6_VOLT 8'h58
`define IDX_LDO6_CTL 8'h59
`define IDX_FAULT_STATUS 8'hD0
`define IDX_FAULT_MASK 8'hD1

// Control register field positions
`define CTL_RUN_BIT 7
`define CTL_AUX_BIT 2
`define CTL_IRQEN_BIT 1
`define CTL_PGOOD_BIT 0

// Voltage code field
`define CODE_MSB 5
`define CODE_WIDTH 6

// Reset values
`define RST_CODE 6'h00
`define RST_CTL 6'h00
`define RST_FAULT_STATUS 6'h00
`define RST_FAULT_MASK 6'h00

// Number of regulator channels
`define NUM_CHANNELS 6

`endif

/* src/regulator_control_registers.v */
// Contract
// RULE_01: Dual-setpoint bucks apply the primary code while select pin is low.
// RULE_02: Dual-setpoint bucks apply the secondary code while select pin is high.
// RULE_03: Control bit 7 enables the regulator and reads back as written.
// RULE_04: Buck control bit 2 selects 180 degree shifted or in-phase operation.
// RULE_05: Control bit 1 lets the channel fault raise an interrupt, else suppresses.
// RULE_06: Control bit 0 is read-only and reports power-good status.
// RULE_07: LDO control bit 2 enables 1.5k discharge while the channel is shut down.
// RULE_08: LDO channels take one code at 0x50 and 0x58, ignoring the select pin.
// RULE_09: Reserved bits ignore writes and read back as zero.
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "regulator_control_registers_regs.vh"

module regulator_control_registers (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // Pins and analog status, asynchronous
    input wire setpoint_select_pin,
    input wire [5:0] powerGoodIn,
    input wire [5:0] faultIn,
    // Regulator controls
    output reg [5:0] buck2Code,
    output reg [5:0] buck3Code,
    output reg [5:0] buck4Code,
    output reg [5:0] ldo5Code,
    output reg [5:0] ldo6Code,
    output reg [5:0] regulatorEnable,
    output reg [3:0] buckPhaseShift,
    output reg [1:0] ldoDischarge,
    // Interrupt
    output reg irq
);

    // Two-flop synchronisers for all asynchronous inputs
    // Packing: bit 12 select pin, bits 11:6 power good, bits 5:0 fault levels
    // Two cycles of latency are traded for a clean sample of slow pins
    reg [12:0] syncMeta;
    reg [12:0] syncOut;
    wire selSync;
    wire [5:0] pgoodSync;
    wire [5:0] faultSync;

    // Stored voltage codes
    reg [5:0] buck2Pri;
    reg [5:0] buck2Sec;
    reg [5:0] buck3Pri;
    reg [5:0] buck3Sec;
    reg [5:0] buck4Pri;
    reg [5:0] buck4Sec;
    reg [5:0] ldo5Volt;
    reg [5:0] ldo6Volt;

    // Control bits, one per channel: 0 is buck1 .. 5 is ldo6
    // The same channel order holds on the enable, power-good and fault ports
    reg [5:0] ctlRun;
    reg [5:0] ctlAux;
    reg [5:0] ctlIrqEn;

    // Fault interrupt registers
    reg [5:0] faultPrev;
    reg [5:0] faultStatus;
    reg [5:0] faultMask;
    wire [5:0] faultEvent;
    reg [5:0] next_faultStatus;
    // Status bits that may drive the interrupt line
    wire [5:0] irqCause;

    // Bus decode
    // Each register owns one 32-bit word; bytes 1 to 3 of the word stay empty
    wire [7:0] regIdx;
    wire setupPhase;
    wire accessPhase;
    wire wrEn;
    wire [5:0] wrCode;
    reg [7:0] rdByte;
    reg rdHit;

    assign regIdx = paddr[9:2];
    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    // A refused setup blocks the write through the registered error flag
    // Only byte lane 0 carries register data
    assign wrEn = accessPhase & pwrite & pstrb[0] & ~pslverr;
    assign wrCode = pwdata[`CODE_MSB:0]; // RULE_09
    // Zero wait states; the answer is prepared in the setup cycle
    // A slave needing wait states would hold this low until its data stands
    assign pready = 1'b1;

    // The first flop feeds only the second
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncMeta <= 13'h0000;
            syncOut <= 13'h0000;
        end else begin
            syncMeta <= {setpoint_select_pin, powerGoodIn, faultIn};
            syncOut <= syncMeta;
        end
    end

    // Unpack the synchronised word
    assign selSync = syncOut[12];
    assign pgoodSync = syncOut[11:6];
    assign faultSync = syncOut[5:0];

    // Build a control byte; reserved bits forced to zero
    // One packing for all six control registers keeps them bit-for-bit alike
    function [7:0] ctlByte;
        input runBit;
        input auxBit;
        input irqBit;
        input pgBit;
        begin
            ctlByte = 8'h00;
            ctlByte[`CTL_RUN_BIT] = runBit; // RULE_03
            ctlByte[`CTL_AUX_BIT] = auxBit;
            ctlByte[`CTL_IRQEN_BIT] = irqBit;
            ctlByte[`CTL_PGOOD_BIT] = pgBit; // RULE_06
        end
    endfunction

    // Voltage code registers; bits 7:6 are never stored
    // Dropping the top bits at the flop makes the zero readback hold by width
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buck2Pri <= `RST_CODE;
            buck2Sec <= `RST_CODE;
            buck3Pri <= `RST_CODE;
            buck3Sec <= `RST_CODE;
            buck4Pri <= `RST_CODE;
            buck4Sec <= `RST_CODE;
            ldo5Volt <= `RST_CODE;
            ldo6Volt <= `RST_CODE;
        end else if (wrEn) begin
            case (regIdx)
                `IDX_BUCK2_PRI: begin
                    buck2Pri <= wrCode;
                end
                `IDX_BUCK2_SEC: begin
                    buck2Sec <= wrCode;
                end
                `IDX_BUCK3_PRI: begin
                    buck3Pri <= wrCode;
                end
                `IDX_BUCK3_SEC: begin
                    buck3Sec <= wrCode;
                end
                `IDX_BUCK4_PRI: begin
                    buck4Pri <= wrCode;
                end
                `IDX_BUCK4_SEC: begin
                    buck4Sec <= wrCode;
                end
                `IDX_LDO5_VOLT: begin
                    ldo5Volt <= wrCode; // RULE_08
                end
                `IDX_LDO6_VOLT: begin
                    ldo6Volt <= wrCode; // RULE_08
                end
                default: begin
                end
            endcase
        end
    end

    // Control registers; power-good bit is not writable
    // Bit 0 has no flop here: it always reads the live synchronised level
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctlRun <= `RST_CTL;
            ctlAux <= `RST_CTL;
            ctlIrqEn <= `RST_CTL;
        end else if (wrEn) begin
            case (regIdx)
                `IDX_BUCK1_CTL: begin
                    ctlRun[0] <= pwdata[`CTL_RUN_BIT]; // RULE_03
                    ctlAux[0] <= pwdata[`CTL_AUX_BIT]; // RULE_04
                    ctlIrqEn[0] <= pwdata[`CTL_IRQEN_BIT]; // RULE_05
                end
                `IDX_BUCK2_CTL: begin
                    ctlRun[1] <= pwdata[`CTL_RUN_BIT]; // RULE_03
                    ctlAux[1] <= pwdata[`CTL_AUX_BIT]; // RULE_04
                    ctlIrqEn[1] <= pwdata[`CTL_IRQEN_BIT]; // RULE_05
                end
                `IDX_BUCK3_CTL: begin
                    ctlRun[2] <= pwdata[`CTL_RUN_BIT]; // RULE_03
                    ctlAux[2] <= pwdata[`CTL_AUX_BIT]; // RULE_04
                    ctlIrqEn[2] <= pwdata[`CTL_IRQEN_BIT]; // RULE_05
                end
                `IDX_BUCK4_CTL: begin
                    ctlRun[3] <= pwdata[`CTL_RUN_BIT]; // RULE_03
                    ctlAux[3] <= pwdata[`CTL_AUX_BIT]; // RULE_04
                    ctlIrqEn[3] <= pwdata[`CTL_IRQEN_BIT]; // RULE_05
                end
                `IDX_LDO5_CTL: begin
                    ctlRun[4] <= pwdata[`CTL_RUN_BIT]; // RULE_03
                    ctlAux[4] <= pwdata[`CTL_AUX_BIT]; // RULE_07
                    ctlIrqEn[4] <= pwdata[`CTL_IRQEN_BIT]; // RULE_05
                end
                `IDX_LDO6_CTL: begin
                    ctlRun[5] <= pwdata[`CTL_RUN_BIT]; // RULE_03
                    ctlAux[5] <= pwdata[`CTL_AUX_BIT]; // RULE_07
                    ctlIrqEn[5] <= pwdata[`CTL_IRQEN_BIT]; // RULE_05
                end
                default: begin
                end
            endcase
        end
    end

    // Rising edge of a synchronised fault is one event
    // A fault held high sets its status bit once; software clears it after
    assign faultEvent = faultSync & ~faultPrev;

    // Mask and channel enable must both agree before a bit reaches the line
    assign irqCause = next_faultStatus & faultMask & ctlIrqEn; // RULE_05

    // Write one to clear; a new event in the same cycle wins
    // The clear acts on the old value so a simultaneous set survives
    always @* begin
        next_faultStatus = faultStatus;
        if (wrEn && regIdx == `IDX_FAULT_STATUS) begin
            next_faultStatus = faultStatus & ~pwdata[5:0];
        end
        next_faultStatus = next_faultStatus | faultEvent;
    end

    // Fault status, mask and interrupt line
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            faultPrev <= 6'h00;
            faultStatus <= `RST_FAULT_STATUS;
            faultMask <= `RST_FAULT_MASK;
            irq <= 1'b0;
        end else begin
            faultPrev <= faultSync;
            faultStatus <= next_faultStatus;
            // Mask bits 7:6 are not stored and read as zero
            if (wrEn && regIdx == `IDX_FAULT_MASK) begin
                faultMask <= pwdata[5:0];
            end
            // Channel enable bit and the per-channel mask bit both gate each status bit
            irq <= |irqCause; // RULE_05
        end
    end

    // Read mux; unmapped or unaligned addresses are flagged
    // Writes decode here as well; their read data is zeroed below
    always @* begin
        rdByte = 8'h00;
        rdHit = 1'b1;
        case (regIdx)
            `IDX_BUCK1_CTL: begin
                rdByte = ctlByte(ctlRun[0], ctlAux[0], ctlIrqEn[0], pgoodSync[0]);
            end
            `IDX_BUCK2_PRI: begin
                rdByte = {2'b00, buck2Pri}; // RULE_09
            end
            `IDX_BUCK2_SEC: begin
                rdByte = {2'b00, buck2Sec}; // RULE_09
            end
            `IDX_BUCK2_CTL: begin
                rdByte = ctlByte(ctlRun[1], ctlAux[1], ctlIrqEn[1], pgoodSync[1]);
            end
            `IDX_BUCK3_PRI: begin
                rdByte = {2'b00, buck3Pri};
            end
            `IDX_BUCK3_SEC: begin
                rdByte = {2'b00, buck3Sec};
            end
            `IDX_BUCK3_CTL: begin
                rdByte = ctlByte(ctlRun[2], ctlAux[2], ctlIrqEn[2], pgoodSync[2]);
            end
            `IDX_BUCK4_PRI: begin
                rdByte = {2'b00, buck4Pri};
            end
            `IDX_BUCK4_SEC: begin
                rdByte = {2'b00, buck4Sec};
            end
            `IDX_BUCK4_CTL: begin
                rdByte = ctlByte(ctlRun[3], ctlAux[3], ctlIrqEn[3], pgoodSync[3]);
            end
            `IDX_LDO5_VOLT: begin
                rdByte = {2'b00, ldo5Volt};
            end
            `IDX_LDO5_CTL: begin
                rdByte = ctlByte(ctlRun[4], ctlAux[4], ctlIrqEn[4], pgoodSync[4]);
            end
            `IDX_LDO6_VOLT: begin
                rdByte = {2'b00, ldo6Volt};
            end
            `IDX_LDO6_CTL: begin
                rdByte = ctlByte(ctlRun[5], ctlAux[5], ctlIrqEn[5], pgoodSync[5]);
            end
            `IDX_FAULT_STATUS: begin
                rdByte = {2'b00, faultStatus};
            end
            `IDX_FAULT_MASK: begin
                rdByte = {2'b00, faultMask};
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            rdHit = 1'b0;
        end
    end

    // Answer captured in setup so data comes from flops in access
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= (rdHit && !pwrite) ? {24'h000000, rdByte} : 32'h00000000;
            pslverr <= ~rdHit;
        end else if (!psel) begin
            // The error flag drops once the master leaves the bus
            pslverr <= 1'b0;
        end
    end

    // Applied buck codes follow the select pin; all codes registered for clean outputs
    // All three bucks switch set in the same cycle, so the rails move together
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            buck2Code <= `RST_CODE;
            buck3Code <= `RST_CODE;
            buck4Code <= `RST_CODE;
            ldo5Code <= `RST_CODE;
            ldo6Code <= `RST_CODE;
        end else begin
            buck2Code <= selSync ? buck2Sec : buck2Pri; // RULE_01 RULE_02
            buck3Code <= selSync ? buck3Sec : buck3Pri; // RULE_01 RULE_02
            buck4Code <= selSync ? buck4Sec : buck4Pri; // RULE_01 RULE_02
            // Linear channels never look at the select pin
            ldo5Code <= ldo5Volt; // RULE_08
            ldo6Code <= ldo6Volt; // RULE_08
        end
    end

    // Enables, phase and discharge drives
    // Registered so the analog side sees glitch-free levels
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regulatorEnable <= 6'h00;
            buckPhaseShift <= 4'h0;
            ldoDischarge <= 2'b00;
        end else begin
            regulatorEnable <= ctlRun; // RULE_03
            buckPhaseShift <= ctlAux[3:0]; // RULE_04
            // Discharge only while the output is shut down
            // It never fights a running regulator: the enable forces it off
            ldoDischarge <= ctlAux[5:4] & ~ctlRun[5:4]; // RULE_07
        end
    end

endmodule

`default_nettype wire

/* tb/regulator_control_registers_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "regulator_control_registers_regs.vh"
module regulator_control_registers_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Regulator controls
    input wire logic [5:0] ldo5Code,
    input wire logic [5:0] regulatorEnable,
    input wire logic [3:0] buckPhaseShift,
    input wire logic [1:0] ldoDischarge
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Accepted write; the address is qualified per assertion
    wire logic wrDone = psel & penable & pwrite & pstrb[0];
    pready_now_a: assert property (psel & penable |-> pready) else $error("pready low");
    upper_zero_a: assert property (psel & penable |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    unaligned_err_a: assert property (psel & penable & (paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unaligned access not refused");
    mapped_ok_a: assert property (psel & penable & (paddr == {`IDX_LDO5_VOLT, 2'b00}) |-> !pslverr)
        else $error("mapped access refused");
    enable_copy_a: assert property (wrDone & (paddr == {`IDX_BUCK1_CTL, 2'b00})
        |-> ##2 regulatorEnable[0] == $past(pwdata[7], 2)) else $error("enable not applied");
    phase_copy_a: assert property (wrDone & (paddr == {`IDX_BUCK1_CTL, 2'b00})
        |-> ##2 buckPhaseShift[0] == $past(pwdata[2], 2)) else $error("phase not applied");
    ldo_code_a: assert property (wrDone & (paddr == {`IDX_LDO5_VOLT, 2'b00})
        |-> ##2 ldo5Code == $past(pwdata[5:0], 2)) else $error("ldo code not applied");
    drain_off5_a: assert property (ldoDischarge[0] |-> !regulatorEnable[4])
        else $error("discharge while enabled");
    drain_off6_a: assert property (ldoDischarge[1] |-> !regulatorEnable[5])
        else $error("discharge while enabled");
endmodule
bind regulator_control_registers regulator_control_registers_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ldo5Code(ldo5Code), .regulatorEnable(regulatorEnable),
    .buckPhaseShift(buckPhaseShift), .ldoDischarge(ldoDischarge)
);
`default_nettype wire

/* tb/processor_side_model.sv */
`timescale 1ns/10ps
`default_nettype none
module processor_side_model (
    // Clock and requested levels
    input wire logic sys_clk,
    input wire logic selReq,
    input wire logic [5:0] goodReq,
    input wire logic [5:0] faultReq,
    // Levels seen by the device
    output logic setpoint_select_pin,
    output logic [5:0] powerGoodIn,
    output logic [5:0] faultIn
);
    // Levels move only after an edge, like a real processor GPIO
    initial begin
        setpoint_select_pin = 1'b0;
        powerGoodIn = 6'h00;
        faultIn = 6'h00;
    end
    always @(posedge sys_clk) begin
        setpoint_select_pin <= selReq;
        powerGoodIn <= goodReq;
        faultIn <= faultReq;
    end
endmodule
`default_nettype wire

/* tb/regulator_control_registers_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "regulator_control_registers_regs.vh"
module regulator_control_registers_tb;
    logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic selReq = 1'b0;
    logic [5:0] goodReq = 6'h00, faultReq = 6'h00;
    wire logic pready, pslverr, irq, selPin;
    wire logic [31:0] prdata;
    wire logic [5:0] b2, b3, b4, l5, l6, ena, good, flt;
    wire logic [3:0] phs;
    wire logic [1:0] dsc;
    wire logic [17:0] bucks = {b4, b3, b2};
    int fail_count = 0, samples_checked = 0;
    logic [31:0] q;
    logic e;
    always #2 sys_clk = ~sys_clk;
    regulator_control_registers u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .setpoint_select_pin(selPin),
        .powerGoodIn(good), .faultIn(flt), .buck2Code(b2), .buck3Code(b3), .buck4Code(b4),
        .ldo5Code(l5), .ldo6Code(l6), .regulatorEnable(ena), .buckPhaseShift(phs),
        .ldoDischarge(dsc), .irq(irq));
    processor_side_model u_proc (.sys_clk(sys_clk), .selReq(selReq), .goodReq(goodReq),
        .faultReq(faultReq), .setpoint_select_pin(selPin), .powerGoodIn(good), .faultIn(flt));
    // One APB transfer; entered just after a rising edge
    task apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
        begin
            psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
            pwdata <= {24'h0, d}; pstrb <= 4'hF;
            @(posedge sys_clk);
            penable <= 1'b1;
            // Only the watchdog ends a wait for pready
            do begin
                @(posedge sys_clk);
            end while (pready !== 1'b1);
            q = prdata;
            e = pslverr;
            psel <= 1'b0; penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task give_verdict;
        $display("Counts: %0d checked, %0d mismatched", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Bound well above the roughly 150 cycles the tests use
    initial begin
        #40000;
        fail_count++;
        give_verdict;
    end
    initial begin
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        goodReq <= 6'h01;
        // Each buck follows the select pin; a write above bit 5 is dropped
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 10'h080 + 10'(k) * 10'h040, 8'hC0 + 8'(k));
            apb(1'b1, 10'h084 + 10'(k) * 10'h040, 8'h2A + 8'(k));
            selReq <= 1'b0;
            cyc(6);
            chk("primary code", 32'(6'h00 + k), 32'(bucks[k*6+:6]));
            selReq <= 1'b1;
            cyc(6);
            chk("secondary code", 32'(6'h2A + k), 32'(bucks[k*6+:6]));
            apb(1'b0, 10'h080 + 10'(k) * 10'h040, 8'h00);
            chk("code readback", 32'(8'h00 + k), q);
        end
        $display("Test setpoints done");
        apb(1'b1, {`IDX_BUCK1_CTL, 2'b00}, 8'hFD);
        apb(1'b0, {`IDX_BUCK1_CTL, 2'b00}, 8'h00);
        chk("ctl readback", 32'h85, q);
        chk("enable out", 32'h1, 32'(ena[0]));
        chk("phase out", 32'h1, 32'(phs[0]));
        goodReq <= 6'h00;
        apb(1'b1, {`IDX_BUCK1_CTL, 2'b00}, 8'h01);
        cyc(4);
        apb(1'b0, {`IDX_BUCK1_CTL, 2'b00}, 8'h00);
        chk("ctl power good", 32'h00, q);
        chk("phase off", 32'h0, 32'(phs[0]));
        $display("Test control done");
        // Linear channel ignores the select pin; discharge only while off
        apb(1'b1, {`IDX_LDO5_VOLT, 2'b00}, 8'h3F);
        selReq <= 1'b0;
        cyc(6);
        chk("ldo code", 32'h3F, 32'(l5));
        apb(1'b1, {`IDX_LDO6_CTL, 2'b00}, 8'h04);
        cyc(2);
        chk("discharge active", 32'h2, 32'(dsc));
        apb(1'b1, {`IDX_LDO6_CTL, 2'b00}, 8'h84);
        cyc(2);
        chk("discharge off", 32'h0, 32'(dsc));
        chk("ldo enable", 32'h20, 32'(ena));
        // Second linear channel, with the select pin flipped meanwhile
        apb(1'b1, {`IDX_LDO6_VOLT, 2'b00}, 8'h15);
        selReq <= 1'b1;
        cyc(6);
        chk("ldo6 code", 32'h15, 32'(l6));
        chk("ldo5 code held", 32'h3F, 32'(l5));
        $display("Test linear done");
        // Fault interrupt, then suppression through control bit 1
        apb(1'b1, {`IDX_FAULT_MASK, 2'b00}, 8'h01);
        apb(1'b1, {`IDX_BUCK1_CTL, 2'b00}, 8'h02);
        faultReq <= 6'h01;
        cyc(6);
        chk("irq raised", 32'h1, 32'(irq));
        faultReq <= 6'h00;
        apb(1'b1, {`IDX_FAULT_STATUS, 2'b00}, 8'h01);
        cyc(3);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, {`IDX_BUCK1_CTL, 2'b00}, 8'h00);
        faultReq <= 6'h01;
        cyc(6);
        chk("irq suppressed", 32'h0, 32'(irq));
        apb(1'b0, {`IDX_FAULT_STATUS, 2'b00}, 8'h00);
        chk("fault status", 32'h01, q);
        apb(1'b0, 10'h3FC, 8'h00);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, q);
        apb(1'b0, {`IDX_BUCK1_CTL, 2'b01}, 8'h00);
        chk("unaligned error", 32'h1, 32'(e));
        chk("unaligned data", 32'h0, q);
        $display("Test interrupt done");
        give_verdict;
    end
endmodule
`default_nettype wire
